//--- rtl/agsc_pkg.sv
// agsc_pkg: register map, field layout, reset values and gain codes of the adc gain control
// assumes a classic wishbone slave with 8-bit registers at byte offsets, each in the low byte of the 32-bit data word
package agsc_pkg;
    // register byte offsets
    localparam logic [7:0] AGSC_OFF_FLAGS     = 8'h24;
    localparam logic [7:0] AGSC_OFF_PGA_L     = 8'h3B;
    localparam logic [7:0] AGSC_OFF_PGA_R     = 8'h3C;
    localparam logic [7:0] AGSC_OFF_SOFTSTEP  = 8'h51;
    localparam logic [7:0] AGSC_OFF_TRIM      = 8'h52;
    localparam logic [7:0] AGSC_OFF_VOL_L     = 8'h53;
    localparam logic [7:0] AGSC_OFF_VOL_R     = 8'h54;
    localparam logic [7:0] AGSC_OFF_CTRL      = 8'h60;
    localparam logic [7:0] AGSC_OFF_IMP       = 8'h64;
    // field positions
    localparam int AGSC_FLAG_L_BIT            = 7;
    localparam int AGSC_FLAG_R_BIT            = 3;
    localparam int AGSC_CTRL_PWR_L_BIT        = 0;
    localparam int AGSC_CTRL_PWR_R_BIT        = 1;
    localparam int AGSC_CTRL_AGC_BIT          = 2;
    localparam int AGSC_CTRL_DIFF_BIT         = 3;
    localparam int AGSC_TRIM_R_LSB            = 4;
    // pga gain codes, 0.5 dB per step
    localparam logic [6:0] AGSC_PGA_MAX       = 7'h5F;
    localparam logic [6:0] AGSC_PGA_MUTE      = 7'h00;
    // digital volume codes, two's complement half-dB
    localparam logic [6:0] AGSC_VOL_MIN       = 7'h68;
    localparam logic [6:0] AGSC_VOL_MAX       = 7'h28;
    localparam logic [6:0] AGSC_VOL_RST       = 7'h00;
    localparam logic [2:0] AGSC_TRIM_MAX      = 3'h4;
    // reset values of software registers
    localparam logic [1:0] AGSC_SOFTSTEP_RST  = 2'h0;
    localparam logic [7:0] AGSC_TRIM_RST      = 8'h00;
    localparam logic [3:0] AGSC_CTRL_RST      = 4'h0;
    localparam logic [3:0] AGSC_IMP_RST       = 4'h0;
    // pga base gain in half-dB: single ended 0 dB, differential +6 dB
    localparam logic [7:0] AGSC_DIFF_OFS      = 8'h0C;
    // impedance drop in half-dB per setting step (6 dB)
    localparam logic [7:0] AGSC_IMP_STEP      = 8'h0C;
    // soft-step settings
    typedef enum logic [1:0] {
        AGSC_SS_ONE  = 2'b00,
        AGSC_SS_TWO  = 2'b01,
        AGSC_SS_OFF  = 2'b10,
        AGSC_SS_OFF2 = 2'b11
    } agsc_ss_t;
    // channel power states along the path up -> ramp down -> off, gray except for ramp -> off
    typedef enum logic [1:0] {
        AGSC_CH_OFF  = 2'b00,
        AGSC_CH_ON   = 2'b01,
        AGSC_CH_RAMP = 2'b11
    } agsc_ch_t;
endpackage

//--- rtl/agsc_top.sv
// agsc_top: soft-stepped pga gain, digital volume and fine trim for a stereo adc path
// assumes sample_stb_i is a one-cycle pulse per adc output sample on clock_i
module agsc_step #(
    parameter int W = 7
) (
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic         step_i,
    input  wire logic         two_i,
    input  wire logic         bypass_i,
    input  wire logic         signed_i,
    input  wire logic [W-1:0] rst_val_i,
    input  wire logic [W-1:0] target_i,
    output logic      [W-1:0] cur_o
);
    logic [W-1:0] cur_q;
    logic [W-1:0] cur_d;
    logic         up;
    logic [W-1:0] diff;
    logic [W-1:0] amt;
    assign up   = signed_i ? ($signed(target_i) > $signed(cur_q)) : (target_i > cur_q);
    assign diff = up ? W'(target_i - cur_q) : W'(cur_q - target_i);
    assign amt  = (two_i && diff > W'(1)) ? W'(2) : W'(1);
    always_comb begin
        cur_d = cur_q;
        if (bypass_i)
            cur_d = target_i;
        else if (step_i && target_i != cur_q)
            cur_d = up ? W'(cur_q + amt) : W'(cur_q - amt);
    end
    always_ff @(posedge clock_i) begin
        if (rst_i)
            cur_q <= rst_val_i;
        else if (ce_i)
            cur_q <= cur_d;
    end
    assign cur_o = cur_q;
endmodule

module agsc_top
    import agsc_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // sample timing and agc
    input  wire logic        sample_stb_i,
    input  wire logic [6:0]  agc_gain_l_i,
    input  wire logic [6:0]  agc_gain_r_i,
    // applied gains, half-dB for pga, tenth-dB for digital
    output logic      [7:0]  pga_gain_l_o,
    output logic      [7:0]  pga_gain_r_o,
    output logic      [10:0] dig_gain_l_o,
    output logic      [10:0] dig_gain_r_o,
    output logic             pwr_l_o,
    output logic             pwr_r_o
);

    // software registers
    logic [6:0]  pga_l_q;
    logic [6:0]  pga_r_q;
    logic [6:0]  vol_l_q;
    logic [6:0]  vol_r_q;
    logic [1:0]  ss_q;
    logic [7:0]  trim_q;
    logic [3:0]  ctrl_q;
    logic [3:0]  imp_q;
    // bus answer and channel state
    logic        ack_q;
    logic [31:0] dat_q;
    agsc_ch_t    ch_l_q;
    agsc_ch_t    ch_r_q;
    logic        ph_q;
    // bus decode
    wire        req     = cyc_i && stb_i && !ack_q;
    // a write lands on the edge that sees ack high, while the master still holds it
    wire        wr      = cyc_i && stb_i && ack_q && we_i && sel_i[0];
    wire        hit_pl  = adr_i == AGSC_OFF_PGA_L;
    wire        hit_pr  = adr_i == AGSC_OFF_PGA_R;
    wire        hit_ss  = adr_i == AGSC_OFF_SOFTSTEP;
    wire        hit_tr  = adr_i == AGSC_OFF_TRIM;
    wire        hit_vl  = adr_i == AGSC_OFF_VOL_L;
    wire        hit_vr  = adr_i == AGSC_OFF_VOL_R;
    wire        hit_ct  = adr_i == AGSC_OFF_CTRL;
    wire        hit_im  = adr_i == AGSC_OFF_IMP;
    wire        hit_fl  = adr_i == AGSC_OFF_FLAGS;

    // per-register write strobes
    wire        wen_pl  = wr && hit_pl;
    wire        wen_pr  = wr && hit_pr;
    wire        wen_ss  = wr && hit_ss;
    wire        wen_tr  = wr && hit_tr;
    wire        wen_vl  = wr && hit_vl;
    wire        wen_vr  = wr && hit_vr;
    wire        wen_ct  = wr && hit_ct;
    wire        wen_im  = wr && hit_im;
    // volume codes above +20dB or below -12dB clamp to the range ends
    function automatic logic [6:0] vclamp(input logic [6:0] v);
        if ($signed(v) > $signed(AGSC_VOL_MAX))
            return AGSC_VOL_MAX;
        else if ($signed(v) < $signed(AGSC_VOL_MIN))
            return AGSC_VOL_MIN;
        return v;
    endfunction
    wire [6:0] pclamp_l = (pga_l_q > AGSC_PGA_MAX) ? AGSC_PGA_MAX : pga_l_q;
    wire [6:0] pclamp_r = (pga_r_q > AGSC_PGA_MAX) ? AGSC_PGA_MAX : pga_r_q;
    // agc replaces the software target when enabled
    wire       agc      = ctrl_q[AGSC_CTRL_AGC_BIT];
    wire [6:0] agc_l    = (agc_gain_l_i > AGSC_PGA_MAX) ? AGSC_PGA_MAX : agc_gain_l_i;
    wire [6:0] agc_r    = (agc_gain_r_i > AGSC_PGA_MAX) ? AGSC_PGA_MAX : agc_gain_r_i;
    wire       on_l     = ch_l_q == AGSC_CH_ON;
    wire       on_r     = ch_r_q == AGSC_CH_ON;
    // power-down drives targets to mute / minimum
    wire [6:0] tp_l     = !on_l ? AGSC_PGA_MUTE : (agc ? agc_l : pclamp_l);
    wire [6:0] tp_r     = !on_r ? AGSC_PGA_MUTE : (agc ? agc_r : pclamp_r);
    wire [6:0] tv_l     = !on_l ? AGSC_VOL_MIN : vol_l_q;
    wire [6:0] tv_r     = !on_r ? AGSC_VOL_MIN : vol_r_q;
    // soft-step rate and bypass from the shared field
    wire       ss_off   = ss_q[1];
    wire       ss_two   = ss_q == AGSC_SS_TWO;
    // pga: 0.5dB per sample, or per two samples in slow setting
    wire       pga_step = sample_stb_i && (!ss_two || ph_q);

    wire [6:0] cp_l;
    wire [6:0] cp_r;
    wire [6:0] cv_l;
    wire [6:0] cv_r;
    agsc_step u_pl (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .step_i    (pga_step),
        .two_i     (1'b0),
        .bypass_i  (ss_off),
        .signed_i  (1'b0),
        .rst_val_i (AGSC_PGA_MUTE),
        .target_i  (tp_l),
        .cur_o     (cp_l)
    );
    agsc_step u_pr (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .step_i    (pga_step),
        .two_i     (1'b0),
        .bypass_i  (ss_off),
        .signed_i  (1'b0),
        .rst_val_i (AGSC_PGA_MUTE),
        .target_i  (tp_r),
        .cur_o     (cp_r)
    );
    agsc_step u_vl (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .step_i    (sample_stb_i),
        .two_i     (ss_two),
        .bypass_i  (ss_off),
        .signed_i  (1'b1),
        .rst_val_i (AGSC_VOL_RST),
        .target_i  (tv_l),
        .cur_o     (cv_l)
    );
    agsc_step u_vr (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .step_i    (sample_stb_i),
        .two_i     (ss_two),
        .bypass_i  (ss_off),
        .signed_i  (1'b1),
        .rst_val_i (AGSC_VOL_RST),
        .target_i  (tv_r),
        .cur_o     (cv_r)
    );
    // reached flags: pga and volume both at target
    wire       pga_at_l = cp_l == tp_l;
    wire       pga_at_r = cp_r == tp_r;
    wire       vol_at_l = cv_l == tv_l;
    wire       vol_at_r = cv_r == tv_r;
    wire       done_l   = pga_at_l && vol_at_l;
    wire       done_r   = pga_at_r && vol_at_r;
    wire [7:0] flags    = {done_l, 3'h0, done_r, 3'h0};
    // fine trim, codes above 4 clamp to -0.4dB
    wire [2:0] tr_l     = (trim_q[2:0] > AGSC_TRIM_MAX) ? AGSC_TRIM_MAX : trim_q[2:0];
    wire [2:0] tr_r     = (trim_q[6:4] > AGSC_TRIM_MAX) ? AGSC_TRIM_MAX : trim_q[6:4];
    // effective pga in half-dB: base, differential offset, impedance drop
    function automatic logic [7:0] pga_eff(input logic [6:0] c, input logic [1:0] imp);
        logic [7:0] g;
        g = {1'b0, c} + (ctrl_q[AGSC_CTRL_DIFF_BIT] ? AGSC_DIFF_OFS : 8'h00);
        return 8'(g - 8'(imp) * AGSC_IMP_STEP);
    endfunction
    wire [1:0] imp_l    = (imp_q[1:0] == 2'h3) ? 2'h2 : imp_q[1:0];
    wire [1:0] imp_r    = (imp_q[3:2] == 2'h3) ? 2'h2 : imp_q[3:2];
    // digital gain in tenth-dB: volume*5 minus trim
    wire [10:0] dg_l    = 11'($signed({{4{cv_l[6]}}, cv_l}) * 11'sd5) - 11'(tr_l);
    wire [10:0] dg_r    = 11'($signed({{4{cv_r[6]}}, cv_r}) * 11'sd5) - 11'(tr_r);
    // read mux, unmapped reads zero
    logic [7:0] rd;
    always_comb begin
        rd = 8'h00;
        if (hit_pl) rd = {1'b0, pga_l_q};
        if (hit_pr) rd = {1'b0, pga_r_q};
        if (hit_ss) rd = {6'h00, ss_q};
        if (hit_tr) rd = trim_q;
        if (hit_vl) rd = {1'b0, vol_l_q};
        if (hit_vr) rd = {1'b0, vol_r_q};
        if (hit_ct) rd = {4'h0, ctrl_q};
        if (hit_im) rd = {4'h0, imp_q};
        if (hit_fl) rd = flags;
    end
    // power sequencing: ramp gains down before turning a channel off
    function automatic agsc_ch_t ch_next(input agsc_ch_t s, input logic en, input logic dn);
        case (s)
            AGSC_CH_OFF:  return en ? AGSC_CH_ON : AGSC_CH_OFF;
            AGSC_CH_ON:   return en ? AGSC_CH_ON : AGSC_CH_RAMP;
            AGSC_CH_RAMP: return en ? AGSC_CH_ON : (dn ? AGSC_CH_OFF : AGSC_CH_RAMP);
            default:      return AGSC_CH_OFF;
        endcase
    endfunction

    // software register writes, low byte only
    always_ff @(posedge clock_i) begin
        if (rst_i)
            pga_l_q <= AGSC_PGA_MUTE;
        else if (ce_i && wen_pl)
            pga_l_q <= dat_i[6:0];
    end
    always_ff @(posedge clock_i) begin
        if (rst_i)
            pga_r_q <= AGSC_PGA_MUTE;
        else if (ce_i && wen_pr)
            pga_r_q <= dat_i[6:0];
    end
    always_ff @(posedge clock_i) begin
        if (rst_i)
            ss_q <= AGSC_SOFTSTEP_RST;
        else if (ce_i && wen_ss)
            ss_q <= dat_i[1:0];
    end
    always_ff @(posedge clock_i) begin
        if (rst_i)
            trim_q <= AGSC_TRIM_RST;
        else if (ce_i && wen_tr)
            trim_q <= {1'b0, dat_i[6:4], 1'b0, dat_i[2:0]};
    end
    always_ff @(posedge clock_i) begin
        if (rst_i)
            vol_l_q <= AGSC_VOL_RST;
        else if (ce_i && wen_vl)
            vol_l_q <= vclamp(dat_i[6:0]);
    end
    always_ff @(posedge clock_i) begin
        if (rst_i)
            vol_r_q <= AGSC_VOL_RST;
        else if (ce_i && wen_vr)
            vol_r_q <= vclamp(dat_i[6:0]);
    end
    always_ff @(posedge clock_i) begin
        if (rst_i)
            ctrl_q <= AGSC_CTRL_RST;
        else if (ce_i && wen_ct)
            ctrl_q <= dat_i[3:0];
    end
    always_ff @(posedge clock_i) begin
        if (rst_i)
            imp_q <= AGSC_IMP_RST;
        else if (ce_i && wen_im)
            imp_q <= dat_i[3:0];
    end

    // bus answer, one cycle after the request is taken
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_q <= req;
            dat_q <= req ? {24'h00_0000, rd} : 32'h0000_0000;
        end
    end

    // both gains at their floor, power may go
    wire       dn_l     = cp_l == AGSC_PGA_MUTE && cv_l == AGSC_VOL_MIN;
    wire       dn_r     = cp_r == AGSC_PGA_MUTE && cv_r == AGSC_VOL_MIN;
    always_ff @(posedge clock_i) begin
        if (rst_i)
            ch_l_q <= AGSC_CH_OFF;
        else if (ce_i)
            ch_l_q <= ch_next(ch_l_q, ctrl_q[AGSC_CTRL_PWR_L_BIT], dn_l);
    end
    always_ff @(posedge clock_i) begin
        if (rst_i)
            ch_r_q <= AGSC_CH_OFF;
        else if (ce_i)
            ch_r_q <= ch_next(ch_r_q, ctrl_q[AGSC_CTRL_PWR_R_BIT], dn_r);
    end

    // sample parity for the every-second-sample pga rate
    always_ff @(posedge clock_i) begin
        if (rst_i)
            ph_q <= 1'b0;
        else if (ce_i && sample_stb_i)
            ph_q <= !ph_q;
    end

    // registered outputs
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pga_gain_l_o <= 8'h00;
            pga_gain_r_o <= 8'h00;
        end else if (ce_i) begin
            pga_gain_l_o <= pga_eff(cp_l, imp_l);
            pga_gain_r_o <= pga_eff(cp_r, imp_r);
        end
    end
    // digital gain moves only with a sample
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            dig_gain_l_o <= 11'h000;
            dig_gain_r_o <= 11'h000;
        end else if (ce_i && sample_stb_i) begin
            dig_gain_l_o <= dg_l;
            dig_gain_r_o <= dg_r;
        end
    end
    // power outputs follow the channel state
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pwr_l_o <= 1'b0;
            pwr_r_o <= 1'b0;
        end else if (ce_i) begin
            pwr_l_o <= ch_l_q != AGSC_CH_OFF;
            pwr_r_o <= ch_r_q != AGSC_CH_OFF;
        end
    end
    assign ack_o = ack_q;
    assign dat_o = dat_q;
endmodule

//--- testbench/agsc_assertions.sv
// agsc_assertions: port-level checks of the adc gain control, bound onto agsc_top
// assumes one clock domain and a synchronous active-high reset
module agsc_assertions
    import agsc_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_o,
    input  wire logic        ack_o,
    input  wire logic        sample_stb_i,
    input  wire logic [7:0]  pga_gain_l_o,
    input  wire logic [10:0] dig_gain_l_o,
    input  wire logic        pwr_l_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    AST_ACK_NEXT: assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o)
        else $error("no ack one cycle after request");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    AST_FLAGS: assert property (ack_o && $past(adr_i) == AGSC_OFF_FLAGS && !$past(we_i)
        |-> dat_o[31:8] == 24'h0 && dat_o[6:4] == 3'h0 && dat_o[2:0] == 3'h0)
        else $error("flags word carries bits other than the two flags");
    AST_RST_MUTE: assert property (disable iff (1'b0) rst_i
        |=> pga_gain_l_o == 8'h00 && !pwr_l_o && dig_gain_l_o == 11'h000)
        else $error("gain not muted after reset");
    AST_DIG_HOLD: assert property (!sample_stb_i |=> $stable(dig_gain_l_o))
        else $error("digital gain moved without a sample");
    AST_PGA_RANGE: assert property ($signed(pga_gain_l_o) <= 107
        && $signed(pga_gain_l_o) >= -24)
        else $error("pga gain out of range");
    AST_DIG_RANGE: assert property ($signed(dig_gain_l_o) <= 200
        && $signed(dig_gain_l_o) >= -124)
        else $error("digital gain out of range");
    AST_PWR_MUTE: assert property ($fell(pwr_l_o) |-> $signed(pga_gain_l_o) <= 12)
        else $error("channel off before pga reached mute");
    cover property ($fell(pwr_l_o));
    cover property (sample_stb_i ##1 $changed(dig_gain_l_o));
    cover property (ack_o && !we_i);
endmodule

bind agsc_top agsc_assertions u_chk (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .sample_stb_i(sample_stb_i), .pga_gain_l_o(pga_gain_l_o), .dig_gain_l_o(dig_gain_l_o),
    .pwr_l_o(pwr_l_o));

//--- testbench/agsc_top_test.sv
// agsc_top_test: register-level tests of the adc gain control over wishbone
// assumes the checker file is compiled alongside and binds itself
module agsc_top_test
    import agsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock_i = 1'b0;
    logic        rst_i, ce_i, cyc_i, stb_i, we_i, sample_stb_i, ack_o, pwr_l_o, pwr_r_o;
    logic [7:0]  adr_i, pga_gain_l_o, pga_gain_r_o;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic [6:0]  agc_gain_l_i, agc_gain_r_i;
    logic [10:0] dig_gain_l_o, dig_gain_r_o;
    int          err_total = 0;
    int          tests_run = 0;
    int          n;
    agsc_top uut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .sample_stb_i(sample_stb_i), .agc_gain_l_i(agc_gain_l_i), .agc_gain_r_i(agc_gain_r_i),
        .pga_gain_l_o(pga_gain_l_o), .pga_gain_r_o(pga_gain_r_o), .dig_gain_l_o(dig_gain_l_o),
        .dig_gain_r_o(dig_gain_r_o), .pwr_l_o(pwr_l_o), .pwr_r_o(pwr_r_o));
    always #2.5 clock_i = ~clock_i;
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, s, e);
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] r);
        int k;
        k = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clock_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        r = dat_o;
        if (k >= 50) check(0, 1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic smp(input int c);
        repeat (c) begin
            sample_stb_i <= 1'b1;
            @(posedge clock_i);
            sample_stb_i <= 1'b0;
            repeat (3) @(posedge clock_i);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #50us;
        err_total++;
        wrap_up();
    end
    initial begin
        {rst_i, ce_i, sel_i} = 6'h3F;
        {cyc_i, stb_i, we_i, sample_stb_i, adr_i, dat_i} = '0;
        {agc_gain_l_i, agc_gain_r_i} = '0;
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        check({pwr_l_o, pga_gain_l_o}, 0);
        bus(0, AGSC_OFF_PGA_L, 0, q);
        check(q, 0);
        bus(0, AGSC_OFF_VOL_L, 0, q);
        check(q, {25'h0, AGSC_VOL_RST});
        bus(1, 8'h10, 8'h5A, q);
        bus(0, 8'h10, 0, q);
        check(q, 0);
        // no-step mode: target applied at once, volume minus trim
        bus(1, AGSC_OFF_SOFTSTEP, 8'h02, q);
        bus(1, AGSC_OFF_CTRL, 8'h01, q);
        bus(1, AGSC_OFF_PGA_L, 8'h10, q);
        bus(1, AGSC_OFF_VOL_L, 8'h04, q);
        bus(1, AGSC_OFF_TRIM, 8'h02, q);
        smp(2);
        check($signed(pga_gain_l_o), 16);
        check($signed(dig_gain_l_o), 18);
        check({pwr_l_o, pga_gain_r_o}, 9'h100);
        bus(0, AGSC_OFF_FLAGS, 0, q);
        check(q[7], 1);
        sel_i <= 4'h0;
        bus(1, AGSC_OFF_PGA_L, 8'h20, q);
        sel_i <= 4'hF;
        bus(0, AGSC_OFF_PGA_L, 0, q);
        check(q, 32'h10);
        // clamps of pga code, volume and trim
        bus(1, AGSC_OFF_PGA_L, 8'h7F, q);
        bus(1, AGSC_OFF_VOL_L, 8'h30, q);
        bus(0, AGSC_OFF_VOL_L, 0, q);
        check(q, {25'h0, AGSC_VOL_MAX});
        bus(1, AGSC_OFF_TRIM, 8'h07, q);
        smp(2);
        check($signed(pga_gain_l_o), 95);
        check($signed(dig_gain_l_o), 196);
        bus(1, AGSC_OFF_VOL_L, 8'h50, q);
        bus(0, AGSC_OFF_VOL_L, 0, q);
        check(q, {25'h0, AGSC_VOL_MIN});
        // differential input across the three impedance settings
        bus(1, AGSC_OFF_PGA_L, 8'h10, q);
        bus(1, AGSC_OFF_CTRL, 8'h09, q);
        for (n = 0; n < 3; n++) begin
            bus(1, AGSC_OFF_IMP, 8'(n), q);
            smp(1);
            check($signed(pga_gain_l_o), 28 - 12 * n);
        end
        bus(1, AGSC_OFF_IMP, 8'h00, q);
        agc_gain_l_i <= 7'h30;
        bus(1, AGSC_OFF_CTRL, 8'h05, q);
        smp(1);
        check($signed(pga_gain_l_o), 48);
        bus(1, AGSC_OFF_CTRL, 8'h01, q);
        bus(1, AGSC_OFF_VOL_L, 8'h00, q);
        bus(1, AGSC_OFF_TRIM, 8'h00, q);
        smp(1);
        // one step per sample
        bus(1, AGSC_OFF_SOFTSTEP, 8'h00, q);
        bus(1, AGSC_OFF_PGA_L, 8'h14, q);
        bus(1, AGSC_OFF_VOL_L, 8'h04, q);
        smp(1);
        check($signed(pga_gain_l_o), 17);
        bus(0, AGSC_OFF_FLAGS, 0, q);
        check(q[7], 0);
        smp(4);
        check($signed(pga_gain_l_o), 20);
        check($signed(dig_gain_l_o), 20);
        bus(0, AGSC_OFF_FLAGS, 0, q);
        check(q[7], 1);
        // pga every second sample, volume two steps per sample
        bus(1, AGSC_OFF_SOFTSTEP, 8'h01, q);
        bus(1, AGSC_OFF_PGA_L, 8'h16, q);
        bus(1, AGSC_OFF_VOL_L, 8'h0A, q);
        smp(2);
        check($signed(pga_gain_l_o), 21);
        smp(2);
        check($signed(pga_gain_l_o), 22);
        check($signed(dig_gain_l_o), 50);
        // power-down ramps both gains before the channel goes off
        bus(1, AGSC_OFF_SOFTSTEP, 8'h00, q);
        bus(1, AGSC_OFF_CTRL, 8'h00, q);
        smp(1);
        check(pwr_l_o, 1);
        for (n = 0; n < 100 && pwr_l_o === 1'b1; n++) smp(1);
        smp(1);
        check({pwr_l_o, pga_gain_l_o}, 0);
        check($signed(dig_gain_l_o), -120);
        // right channel alone
        bus(1, AGSC_OFF_SOFTSTEP, 8'h02, q);
        bus(1, AGSC_OFF_CTRL, 8'h02, q);
        bus(1, AGSC_OFF_PGA_R, 8'h08, q);
        bus(1, AGSC_OFF_VOL_R, 8'h02, q);
        bus(1, AGSC_OFF_TRIM, 8'h10, q);
        smp(2);
        check({pwr_r_o, pga_gain_r_o, pga_gain_l_o}, 17'h10800);
        check($signed(dig_gain_r_o), 9);
        bus(0, AGSC_OFF_FLAGS, 0, q);
        check(q[3], 1);
        // clock enable low freezes stepping and the sampled gain
        bus(1, AGSC_OFF_SOFTSTEP, 8'h00, q);
        bus(1, AGSC_OFF_VOL_R, 8'h06, q);
        ce_i <= 1'b0;
        smp(4);
        check($signed(dig_gain_r_o), 9);
        ce_i <= 1'b1;
        smp(5);
        check($signed(dig_gain_r_o), 29);
        // reset in mid-run mutes again
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        check({pwr_r_o, pga_gain_r_o}, 0);
        bus(0, AGSC_OFF_PGA_R, 0, q);
        check(q, 0);
        wrap_up();
    end
endmodule
